// file: rtl/bridge_regs_pkg.sv
/*
 * Package for the bridge window and control register bank: offsets,
 * reset values, field positions and carrier structs.
 * Assumes one 100 MHz core clock and AHB-Lite register access.
 */
package bridge_regs_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_PF_BASE_HI = 8'h28;
  localparam logic [7:0] OFF_PF_LIMIT_HI = 8'h2c;
  localparam logic [7:0] OFF_IO_HI = 8'h30;
  localparam logic [7:0] OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] OFF_INT_CTRL = 8'h3c;
  localparam logic [7:0] OFF_PF_BASE_LO = 8'h40;
  localparam logic [7:0] OFF_PF_LIMIT_LO = 8'h44;
  localparam logic [7:0] OFF_IO_LO = 8'h48;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h4c;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h50;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h54;
  localparam logic [7:0] OFF_PORT_CFG = 8'h58;

  // ************************************************************
  // Reset values and constants
  // ************************************************************
  localparam logic [31:0] PF_HI_RESET = 32'h0000_0000;
  localparam logic [15:0] IO_HI_RESET = 16'h0000;
  localparam logic [7:0] CAP_PTR_VALUE = 8'h80;
  localparam logic [7:0] INT_LINE_RESET = 8'h00;
  localparam logic [7:0] INT_PIN_RESET = 8'h00;
  localparam logic [11:0] PF_LO_RESET = 12'h000;
  localparam logic [19:0] PF_LOW_ONES = 20'hfffff;
  localparam logic [3:0] PF_ADDR64 = 4'h1;
  localparam logic [31:0] VGA_MEM_LO = 32'h000a_0000;
  localparam logic [31:0] VGA_MEM_HI = 32'h000b_ffff;
  localparam logic [9:0] VGA_IO_A_LO = 10'h3b0;
  localparam logic [9:0] VGA_IO_A_HI = 10'h3bb;
  localparam logic [9:0] VGA_IO_B_LO = 10'h3c0;
  localparam logic [9:0] VGA_IO_B_HI = 10'h3df;
  localparam logic [9:0] ISA_ALIAS_START = 10'h100;
  localparam int unsigned LEGACY_PORT = 2;

  // Bridge control bit positions within the 0x3c word
  localparam int unsigned BC_POISON = 16;
  localparam int unsigned BC_ERRFWD = 17;
  localparam int unsigned BC_ISA = 18;
  localparam int unsigned BC_VGA = 19;
  localparam int unsigned BC_VGA16 = 20;
  localparam int unsigned BC_SBR = 22;

  // Interrupt status bit positions
  localparam int unsigned EV_POISON = 0;
  localparam int unsigned EV_ERRFWD = 1;
  localparam int unsigned EV_RESET = 2;
  localparam int unsigned EV_WIDTH = 3;

  // ************************************************************
  // Carrier structs
  // ************************************************************
  typedef struct packed {
    logic sel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic ready;
  } ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_s;

  typedef struct packed {
    logic mem_valid;
    logic [63:0] mem_addr;
    logic io_valid;
    logic [31:0] io_addr;
    logic poisoned_tlp;
    logic err_msg;
  } fwd_req_s;

  typedef struct packed {
    logic mem_down;
    logic io_down;
    logic io_up;
    logic poison_report;
    logic err_forward;
  } fwd_rsp_s;

endpackage

// file: rtl/window_match.sv
/*
 * Inclusive range compare used for the prefetchable and I/O forwarding windows.
 * Assumes base and limit are already assembled to full width.
 */
`timescale 1ns/1ps
module window_match #(
  parameter int unsigned W = 32
) (
  input wire logic [W-1:0] addr_in,   // Address under test
  input wire logic [W-1:0] base_in,   // Inclusive bottom
  input wire logic [W-1:0] limit_in,  // Inclusive top
  output logic hit_out                // Address inside range
);
  assign hit_out = (addr_in >= base_in) && (addr_in <= limit_in);
endmodule

// file: rtl/bridge_window_and_control_regs.sv
/*
 * Upper type-1 header registers and bridge control of one bridge port,
 * plus the forwarding decode those registers steer.
 * Assumes AHB-Lite single word transfers and synchronous forwarding inputs.
 * Reads take one wait state; hsize is accepted but never checked.
 */
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module bridge_window_and_control_regs
  import bridge_regs_pkg::*;
#(
  parameter int unsigned PORT_NUM = 1,
  parameter int unsigned NUM_DOWN = 2
) (
  input wire logic clk_sys_in,                          // Core clock 100 MHz
  input wire logic srst_in,                             // Sync reset, high
  input wire logic clk_en_in,                           // Freeze when low
  input wire logic is_upstream_in,                      // Port is upstream
  input wire logic hsel_in,                             // AHB select
  input wire logic [1:0] htrans_in,                     // AHB transfer type
  input wire logic [31:0] haddr_in,                     // AHB address
  input wire logic hwrite_in,                           // AHB write
  input wire logic [2:0] hsize_in,                      // AHB size
  input wire logic [31:0] hwdata_in,                    // AHB write data
  input wire logic hready_in,                           // AHB bus ready
  output logic [31:0] hrdata_out,                       // AHB read data
  output logic hreadyout_out,                           // AHB slave ready
  output logic hresp_out,                               // AHB response
  input wire bridge_regs_pkg::fwd_req_s fwd_req_in,     // Decode request
  output bridge_regs_pkg::fwd_rsp_s fwd_rsp_out,        // Decode result
  output logic [NUM_DOWN-1:0] port_rst_n_out,           // Port resets, low
  output logic irq_out                                  // Level interrupt
);

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } bus_phase_e;

  // Every flop of the block lives in this one struct, so the clock enable
  // freezes all of it in a single place and no field can be missed
  typedef struct packed {
    bus_phase_e phase;
    logic [7:0] addr;
    logic [31:0] pf_base_hi;
    logic [31:0] pf_limit_hi;
    logic [15:0] io_base_hi;
    logic [15:0] io_limit_hi;
    logic [11:0] pf_base_lo;
    logic [11:0] pf_limit_lo;
    logic [15:0] io_base_lo;
    logic [15:0] io_limit_lo;
    logic [7:0] int_line;
    logic poison_en;
    logic secondary_error_forward_enable;
    logic legacy_io_alias_enable;
    logic vga_en;
    logic vga16;
    logic sec_reset;
    logic [EV_WIDTH-1:0] irq_status;
    logic [EV_WIDTH-1:0] irq_enable;
    logic [31:0] hrdata;
    logic ready; // Low during a read's wait state
    logic irq;
    logic [NUM_DOWN-1:0] port_rst_n;
    fwd_rsp_s fwd;
  } state_s;

  state_s state_q;
  state_s state_d;

  // ************************************************************
  // Window assembly and compare
  // ************************************************************
  logic [63:0] pf_base;
  logic [63:0] pf_limit;
  logic [31:0] io_base;
  logic [31:0] io_limit;
  logic pf_hit;
  logic io_hit;
  logic vga_legal;

  // Bounds are rebuilt every cycle from the stored fields; a base above its
  // limit simply gives an empty window, which is how software closes one
  // low bits zero and ones
  assign pf_base = {state_q.pf_base_hi, state_q.pf_base_lo, 20'h00000};
  assign pf_limit = {state_q.pf_limit_hi, state_q.pf_limit_lo, PF_LOW_ONES};
  assign io_base = {state_q.io_base_hi, state_q.io_base_lo};
  assign io_limit = {state_q.io_limit_hi, state_q.io_limit_lo};
  assign vga_legal = (PORT_NUM != LEGACY_PORT);

  // One comparator per window; the prefetch compare is a full 64-bit one
  window_match #(.W(64)) u_pf_match (
    .addr_in(fwd_req_in.mem_addr),
    .base_in(pf_base),
    .limit_in(pf_limit),
    .hit_out(pf_hit)
  );

  window_match #(.W(32)) u_io_match (
    .addr_in(fwd_req_in.io_addr),
    .base_in(io_base),
    .limit_in(io_limit),
    .hit_out(io_hit)
  );

  // ************************************************************
  // Legacy decode terms
  // ************************************************************
  logic vga_mem_hit;
  logic vga_io_hit;
  logic isa_alias;
  logic [9:0] io_low10;

  // Video and alias terms only look at the first 64KB of I/O space; the
  // upper half-word must be zero before any low-bit compare counts
  assign io_low10 = fwd_req_in.io_addr[9:0];

  assign vga_mem_hit = (fwd_req_in.mem_addr >= {32'h0, VGA_MEM_LO}) &&
                       (fwd_req_in.mem_addr <= {32'h0, VGA_MEM_HI});

  // With 10-bit decode the video ranges repeat every 1KB, as older cards
  // expect; 16-bit decode also demands that bits 15:10 be zero
  // video I/O, 10 or 16 bit
  assign vga_io_hit = (((io_low10 >= VGA_IO_A_LO) && (io_low10 <= VGA_IO_A_HI)) ||
                       ((io_low10 >= VGA_IO_B_LO) && (io_low10 <= VGA_IO_B_HI))) &&
                      (fwd_req_in.io_addr[31:16] == 16'h0000) &&
                      (!state_q.vga16 || (fwd_req_in.io_addr[15:10] == 6'h00));

  assign isa_alias = (fwd_req_in.io_addr[31:16] == 16'h0000) &&
                     (io_low10 >= ISA_ALIAS_START);

  // ************************************************************
  // Read mux
  // ************************************************************
  logic [31:0] rd_word;
  logic [31:0] ctrl_word;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[7:0] = state_q.int_line;
    ctrl_word[15:8] = INT_PIN_RESET;  // fixed pin
    ctrl_word[BC_POISON] = state_q.poison_en;
    ctrl_word[BC_ERRFWD] = state_q.secondary_error_forward_enable;
    ctrl_word[BC_ISA] = state_q.legacy_io_alias_enable;
    ctrl_word[BC_VGA] = state_q.vga_en;
    ctrl_word[BC_VGA16] = state_q.vga16;
    ctrl_word[BC_SBR] = state_q.sec_reset;
  end

  // Holes and the write-only clear register read as zero, so probing an
  // unmapped offset never returns stale data
  always_comb begin
    case (state_q.addr)
      OFF_PF_BASE_HI: rd_word = state_q.pf_base_hi;
      OFF_PF_LIMIT_HI: rd_word = state_q.pf_limit_hi;
      OFF_IO_HI: rd_word = {state_q.io_limit_hi, state_q.io_base_hi};
      OFF_CAP_PTR: rd_word = {24'h000000, CAP_PTR_VALUE};
      OFF_INT_CTRL: rd_word = ctrl_word;
      OFF_PF_BASE_LO: rd_word = {16'h0000, state_q.pf_base_lo, PF_ADDR64};
      OFF_PF_LIMIT_LO: rd_word = {state_q.pf_limit_lo, PF_ADDR64, 16'h0000};
      OFF_IO_LO: rd_word = {state_q.io_limit_lo, state_q.io_base_lo};
      OFF_IRQ_STATUS: rd_word = {29'h0, state_q.irq_status};
      OFF_IRQ_ENABLE: rd_word = {29'h0, state_q.irq_enable};
      OFF_PORT_CFG: rd_word = {29'h0, is_upstream_in, vga_legal, 1'b0};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  logic take;
  logic [EV_WIDTH-1:0] events;
  logic [EV_WIDTH-1:0] clr_mask;
  logic [31:0] w;

  // A transfer is accepted only while the bus is ready; hsize is ignored,
  // since every register is one aligned word: a narrow write still
  // updates the whole word, a limitation software must respect
  assign take = hsel_in && hready_in && htrans_in[1];
  assign w = hwdata_in;

  always_comb begin
    state_d = state_q;
    events = '0;
    clr_mask = '0;
    state_d.hrdata = 32'h0000_0000;

    // Data phase of a previous write lands here, address phase latched
    if (state_q.phase == BUS_WRITE) begin
      case (state_q.addr)
        OFF_PF_BASE_HI: state_d.pf_base_hi = w;
        OFF_PF_LIMIT_HI: state_d.pf_limit_hi = w;
        OFF_IO_HI: begin
          state_d.io_base_hi = w[15:0];
          state_d.io_limit_hi = w[31:16];
        end
        OFF_INT_CTRL: begin
          // Bits 21 and 23-31 have no flop, so writes to them are dropped
          state_d.int_line = w[7:0];
          state_d.poison_en = w[BC_POISON];
          state_d.secondary_error_forward_enable = w[BC_ERRFWD];
          state_d.legacy_io_alias_enable = w[BC_ISA];
          state_d.vga_en = vga_legal & w[BC_VGA];
          state_d.vga16 = vga_legal & w[BC_VGA16];
          state_d.sec_reset = w[BC_SBR];
        end
        OFF_PF_BASE_LO: state_d.pf_base_lo = w[15:4];
        OFF_PF_LIMIT_LO: state_d.pf_limit_lo = w[31:20];
        OFF_IO_LO: begin
          state_d.io_base_lo = w[15:0];
          state_d.io_limit_lo = w[31:16];
        end
        OFF_IRQ_ENABLE: state_d.irq_enable = w[EV_WIDTH-1:0];
        // Clear register is write-only; its mask lives for one cycle
        OFF_IRQ_CLEAR: clr_mask = w[EV_WIDTH-1:0];
        default: ;
      endcase
    end

    // Address phase; writes need no wait, reads get one
    if (hready_in) begin
      state_d.phase = BUS_IDLE;
      if (take) begin
        state_d.addr = haddr_in[7:0];
        state_d.phase = hwrite_in ? BUS_WRITE : BUS_READ;
      end
    end

    // Read wait state: the word is registered in the first data cycle, from
    // registers that already hold any write finished on the same edge.
    // Costs a cycle per read, but needs no bypass around the write decode.
    state_d.ready = 1'b1;
    if (take && !hwrite_in) begin
      state_d.ready = 1'b0;
    end
    // Phase stays BUS_READ through the wait, so the word stands when sampled
    if (state_q.phase == BUS_READ) begin
      state_d.hrdata = rd_word;
    end

    // Forward decode is one registered stage; results stand one cycle per
    // sampled request, with no queue behind them
    // poisoned TLP detect gate
    state_d.fwd.poison_report = fwd_req_in.poisoned_tlp && state_q.poison_en;
    state_d.fwd.err_forward = fwd_req_in.err_msg && state_q.secondary_error_forward_enable;
    state_d.fwd.mem_down = fwd_req_in.mem_valid &&
                           (pf_hit || (state_q.vga_en && vga_mem_hit));
    state_d.fwd.io_up = fwd_req_in.io_valid && io_hit &&
                        state_q.legacy_io_alias_enable && isa_alias &&
                        !(state_q.vga_en && vga_io_hit);
    state_d.fwd.io_down = fwd_req_in.io_valid &&
                          ((io_hit && !(state_q.legacy_io_alias_enable && isa_alias)) ||
                           (state_q.vga_en && vga_io_hit));

    // Port reset is held for as long as bit 22 stays set; software must
    // clear the bit again to release the attached devices
    // hot reset to ports
    if (is_upstream_in) begin
      state_d.port_rst_n = {NUM_DOWN{!state_q.sec_reset}};
    end else begin
      state_d.port_rst_n = {NUM_DOWN{1'b1}};
      state_d.port_rst_n[0] = !state_q.sec_reset;
    end

    // Status bits are sticky: only a write to the clear register drops them
    events[EV_POISON] = state_d.fwd.poison_report;
    events[EV_ERRFWD] = state_d.fwd.err_forward;
    events[EV_RESET] = state_d.sec_reset && !state_q.sec_reset;
    // Set wins over a same-cycle clear
    state_d.irq_status = (state_q.irq_status & ~clr_mask) | events;
    // Interrupt follows the next status, so it never lags a new event
    state_d.irq = |(state_d.irq_status & state_d.irq_enable);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Reset overrides the clock enable, so a frozen block still returns idle
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_q <= '0;
      state_q.phase <= BUS_IDLE;
      state_q.pf_base_hi <= PF_HI_RESET;
      state_q.pf_limit_hi <= PF_HI_RESET;
      state_q.io_base_hi <= IO_HI_RESET;
      state_q.io_limit_hi <= IO_HI_RESET;
      state_q.pf_base_lo <= PF_LO_RESET;
      state_q.pf_limit_lo <= PF_LO_RESET;
      state_q.int_line <= INT_LINE_RESET;
      state_q.port_rst_n <= {NUM_DOWN{1'b1}};
      state_q.ready <= 1'b1;
    end else if (clk_en_in) begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops; reads wait one cycle, always OKAY
  assign hrdata_out = state_q.hrdata;
  assign hreadyout_out = state_q.ready;
  assign hresp_out = 1'b0;
  assign fwd_rsp_out = state_q.fwd;
  assign port_rst_n_out = state_q.port_rst_n;
  assign irq_out = state_q.irq;

endmodule

// file: tb/bridge_regs_monitor.sv
/*
 * Checker for the bridge control register bank, bound to its top module.
 * Assumes it sees only the top module's ports.
 */
`timescale 1ns/1ps
module bridge_regs_monitor
  import bridge_regs_pkg::*;
#(
  parameter int unsigned NUM_DOWN = 2
) (
  input wire logic clk_sys_in, // Core clock
  input wire logic srst_in, // Sync reset
  input wire logic is_upstream_in, // Upstream strap
  input wire logic hsel_in, // Bus select
  input wire logic [1:0] htrans_in, // Transfer type
  input wire logic [31:0] haddr_in, // Bus address
  input wire logic hwrite_in, // Write flag
  input wire logic [31:0] hwdata_in, // Write data
  input wire logic hready_in, // Bus ready
  input wire logic [31:0] hrdata_out, // Read data
  input wire logic hreadyout_out, // Slave ready
  input wire logic hresp_out, // Response
  input wire bridge_regs_pkg::fwd_req_s fwd_req_in, // Decode request
  input wire bridge_regs_pkg::fwd_rsp_s fwd_rsp_out, // Decode result
  input wire logic [NUM_DOWN-1:0] port_rst_n_out, // Port resets
  input wire logic irq_out // Interrupt
);
  logic wr_q;
  logic wr_ctl_q;
  logic [31:0] ctl_q;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  // Shadow of the control word, snooped at the data phase like the slave
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      wr_q <= 1'b0;
      wr_ctl_q <= 1'b0;
      ctl_q <= '0;
    end else begin
      wr_q <= hsel_in & hready_in & htrans_in[1] & hwrite_in;
      wr_ctl_q <= hsel_in & hready_in & htrans_in[1] & hwrite_in & (haddr_in[7:0] == OFF_INT_CTRL);
      if (wr_ctl_q) ctl_q <= hwdata_in;
    end
  end
  sequence taken(logic w, logic [7:0] a);
    hsel_in && hready_in && htrans_in[1] && hwrite_in == w && haddr_in[7:0] == a;
  endsequence
  // A read is answered after exactly one wait cycle
  sequence read_taken;
    hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  endsequence
  sequence read_wait;
    ##1 !hreadyout_out ##1 hreadyout_out;
  endsequence
  bus_okay_a: assert property (!hresp_out && (hreadyout_out ||
    $past(hsel_in && hready_in && htrans_in[1] && !hwrite_in)))
    else $error("slave stalled or gave an error");
  read_wait_a: assert property (read_taken |-> read_wait)
    else $error("read wait state wrong");
  cap_read_a: assert property (taken(1'b0, OFF_CAP_PTR) |->
    read_wait ##0 hrdata_out == 32'h0000_0080)
    else $error("capability pointer read wrong");
  ctl_read_a: assert property (taken(1'b0, OFF_INT_CTRL) |->
    read_wait ##0 hrdata_out == (ctl_q & 32'h005f_00ff))
    else $error("control word read wrong");
  hole_read_a: assert property (taken(1'b0, 8'h60) |->
    read_wait ##0 hrdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  poison_gate_a: assert property (fwd_rsp_out.poison_report == $past(fwd_req_in.poisoned_tlp & ctl_q[BC_POISON]))
    else $error("poison report not gated");
  error_gate_a: assert property (fwd_rsp_out.err_forward == $past(fwd_req_in.err_msg & ctl_q[BC_ERRFWD]))
    else $error("error forward not gated");
  video_mem_a: assert property (fwd_req_in.mem_valid && ctl_q[BC_VGA] &&
    fwd_req_in.mem_addr inside {[64'h000a_0000:64'h000b_ffff]} |=> fwd_rsp_out.mem_down)
    else $error("video memory not forwarded");
  // Judged only once the bit has settled, so either output latency passes
  hot_reset_a: assert property ($stable(ctl_q[BC_SBR]) |-> port_rst_n_out[0] == !ctl_q[BC_SBR])
    else $error("port reset does not follow control");
  spare_rst_a: assert property (!is_upstream_in |-> &port_rst_n_out[NUM_DOWN-1:1])
    else $error("downstream port drove a foreign reset");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("interrupt dropped without a write");
endmodule
bind bridge_window_and_control_regs bridge_regs_monitor #(.NUM_DOWN(NUM_DOWN)) i_bridge_regs_monitor (
  .clk_sys_in, .srst_in, .is_upstream_in, .hsel_in, .htrans_in, .haddr_in, .hwrite_in,
  .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .fwd_req_in, .fwd_rsp_out,
  .port_rst_n_out, .irq_out);

// file: tb/fwd_source_model.sv
/*
 * Source of forwarding requests from the link side of the bridge port.
 * Assumes requests are sampled by the bridge at every rising clock edge.
 */
`timescale 1ns/1ps
module fwd_source_model
  import bridge_regs_pkg::*;
(
  input wire logic clk_sys_in, // Core clock
  output bridge_regs_pkg::fwd_req_s req_out // Request toward the bridge
);
  initial req_out = '0;
  // One-cycle request; addresses then flip so no stale value can match
  task automatic issue(input logic m, io, input logic [63:0] a, input logic p, e);
    @(posedge clk_sys_in);
    req_out <= '{m, a, io, a[31:0], p, e};
    @(posedge clk_sys_in);
    req_out <= '{1'b0, ~a, 1'b0, ~a[31:0], 1'b0, 1'b0};
  endtask
endmodule

// file: tb/tb_bridge_window_and_control_regs.sv
/*
 * Self-checking bench for the bridge window and control registers.
 * Assumes the package, checker and request source are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_bridge_window_and_control_regs;
  import bridge_regs_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic is_upstream_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [1:0] htrans_in = 2'h0;
  logic [31:0] haddr_in = 32'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic [31:0] hrdata_out, rd;
  logic hreadyout_out, hresp_out, irq_out;
  fwd_req_s fwd_req_in;
  fwd_rsp_s fwd_rsp_out;
  logic [1:0] port_rst_n_out;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  bridge_window_and_control_regs #(.PORT_NUM(1), .NUM_DOWN(2)) i_bridge_window_and_control_regs (
    .clk_sys_in, .srst_in, .clk_en_in(1'b1), .is_upstream_in, .hsel_in, .htrans_in,
    .haddr_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out),
    .hrdata_out, .hreadyout_out, .hresp_out, .fwd_req_in, .fwd_rsp_out, .port_rst_n_out,
    .irq_out);
  fwd_source_model i_fwd_source_model (.clk_sys_in, .req_out(fwd_req_in));
  always #5 clk_sys_in = ~clk_sys_in;
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  // ************************************************************
  // Bus and request helpers
  // ************************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic ck(input logic m, io, p, e, input logic [63:0] a, input logic [4:0] x);
    i_fwd_source_model.issue(m, io, a, p, e);
    #1;
    `CHK(fwd_rsp_out, x)
  endtask
  // Registered side effects land within three edges of the write
  task automatic settle();
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    rc(8'h28, 32'h0);
    rc(8'h2c, 32'h0);
    rc(8'h30, 32'h0);
    rc(8'h34, 32'h80);
    rc(8'h3c, 32'h0);
    rc(8'h58, 32'h2);
    wr(8'h28, 32'ha5a5_0f0f);
    rc(8'h28, 32'ha5a5_0f0f);
    wr(8'h2c, 32'h5a5a_f0f0);
    rc(8'h2c, 32'h5a5a_f0f0);
    wr(8'h30, 32'h1234_abcd);
    rc(8'h30, 32'h1234_abcd);
    wr(8'h34, 32'h0);
    rc(8'h34, 32'h80);
    wr(8'h3c, 32'hffff_ffff);
    rc(8'h3c, 32'h005f_00ff);
    wr(8'h60, 32'hffff_ffff);
    rc(8'h60, 32'h0);
    wr(8'h30, 32'h0);
    wr(8'h3c, 32'h0);
    $display("register test done");
  endtask
  task automatic t_ctl();
    for (int v = 0; v < 4; v++) begin
      wr(8'h3c, {14'h0, v[1:0], 16'h0});
      ck(1'b0, 1'b0, 1'b1, 1'b1, 64'h0, {3'h0, v[0], v[1]});
    end
    $display("error gating test done");
  endtask
  task automatic t_window();
    wr(8'h28, 32'h1);
    wr(8'h2c, 32'h1);
    ck(1'b1, 1'b0, 1'b0, 1'b0, 64'h1_0000_0000, 5'b10000);
    ck(1'b1, 1'b0, 1'b0, 1'b0, 64'h1_000f_ffff, 5'b10000);
    ck(1'b1, 1'b0, 1'b0, 1'b0, 64'h1_0010_0000, 5'b00000);
    ck(1'b1, 1'b0, 1'b0, 1'b0, 64'h0_ffff_ffff, 5'b00000);
    $display("window test done");
  endtask
  task automatic t_video();
    wr(8'h3c, 32'h0008_0000);
    ck(1'b1, 1'b0, 1'b0, 1'b0, 64'ha0000, 5'b10000);
    ck(1'b1, 1'b0, 1'b0, 1'b0, 64'hbffff, 5'b10000);
    ck(1'b1, 1'b0, 1'b0, 1'b0, 64'hc0000, 5'b00000);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h3bb, 5'b01000);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h3bc, 5'b00000);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h3df, 5'b01000);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h7b0, 5'b01000);
    wr(8'h3c, 32'h0018_0000);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h7b0, 5'b00000);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h3c0, 5'b01000);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h1_03c0, 5'b00000);
    wr(8'h3c, 32'h0);
    ck(1'b1, 1'b0, 1'b0, 1'b0, 64'ha0000, 5'b00000);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h3b0, 5'b00000);
    $display("video test done");
  endtask
  task automatic t_alias();
    wr(8'h48, 32'hffff_0000);
    wr(8'h3c, 32'h0004_0000);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h500, 5'b00100);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h4ff, 5'b01000);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h1_0500, 5'b00000);
    wr(8'h3c, 32'h0);
    ck(1'b0, 1'b1, 1'b0, 1'b0, 64'h500, 5'b01000);
    $display("alias test done");
  endtask
  task automatic t_reset_irq();
    wr(8'h54, 32'h7);
    wr(8'h50, 32'h4);
    settle();
    `CHK(irq_out, 1'b0)
    wr(8'h3c, 32'h0040_0000);
    settle();
    `CHK(port_rst_n_out, 2'b10)
    `CHK(irq_out, 1'b1)
    wr(8'h50, 32'h0);
    settle();
    `CHK(irq_out, 1'b0)
    wr(8'h50, 32'h4);
    wr(8'h3c, 32'h0);
    settle();
    `CHK(irq_out, 1'b1)
    `CHK(port_rst_n_out, 2'b11)
    wr(8'h54, 32'h4);
    settle();
    `CHK(irq_out, 1'b0)
    @(posedge clk_sys_in);
    is_upstream_in <= 1'b1;
    wr(8'h3c, 32'h0040_0000);
    settle();
    `CHK(port_rst_n_out, 2'b00)
    $display("reset and interrupt test done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    t_regs();
    t_ctl();
    t_window();
    t_video();
    t_alias();
    t_reset_irq();
    finish_test();
  end
endmodule
